// ===== pkg/adc_regs_cfg.svh
// Offsets, field positions, reset values and command codes of the converter register bank
`ifndef ADC_REGS_CFG_SVH
`define ADC_REGS_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_IDENT        5'h00
`define ADDR_STATUS       5'h01
`define ADDR_CONFIG       5'h02

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STATUS_RESET      8'h01
`define CONFIG_RESET      8'h24

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define CMD_READ_BASE     8'h20
`define CMD_WRITE_BASE    8'h40
`define CMD_OP_MSB        7
`define CMD_OP_LSB        5
`define CMD_ADDR_MSB      4
`define TX_IDLE_BYTE      8'hff
`define TX_ZERO_BYTE      8'h00
`define CRC_POLY          8'h07
`define CRC_INIT          8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STAT_CRC_BIT      6
`define STAT_RST_BIT      0
`define RATE_MSB          7
`define RATE_LSB          3
`define FILT_MSB          2
`define FILT_LSB          0
`define RATE_SINC5_MIN    5'h0d

`endif

// ===== pkg/adc_regs_pkg.sv
// Types shared by the converter register bank
`default_nettype none

package adc_regs_pkg;

    typedef struct packed {
        logic rsvd7;
        logic checksum_fault_primary;
        logic rsvd5;
        logic secondary_error_summary;
        logic reference_low_alarm;
        logic new_result_flag;
        logic clock_external;
        logic reset_seen;
    } main_status_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } link_pins_t;

    typedef enum logic [2:0] {
        FILT_SINC1    = 3'h0,
        FILT_SINC3    = 3'h2,
        FILT_SINC4    = 3'h3,
        FILT_FIR      = 3'h4,
        FILT_SINC5    = 3'h5,
        FILT_RESERVED = 3'h7
    } filter_mode_t;

    typedef enum logic [4:0] {
        PH_CMD   = 5'b00001,
        PH_DATA  = 5'b00010,
        PH_CHECK = 5'b00100,
        PH_REPLY = 5'b01000,
        PH_DONE  = 5'b10000
    } phase_t;

endpackage : adc_regs_pkg

`default_nettype wire

// ===== core/adc_regs.sv
// Identification, main status and rate/filter registers behind the serial command port
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_cfg.svh"

module adc_regs #(
    parameter logic [3:0] PART_CODE = 4'ha,   // Arbitrary value
    parameter logic [3:0] REV_CODE  = 4'h1    // Arbitrary value
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        sclk,
    input  wire logic                        chip_select_converter_n,
    input  wire logic                        din,
    output var  logic                        dout,
    output var  logic                        dout_oe_n,
    input  wire logic                        conversion_start,
    input  wire logic                        conversion_done,
    input  wire logic                        data_read,
    input  wire logic                        reference_below_limit,
    input  wire logic                        clock_external,
    input  wire logic                        secondary_errors_logged,
    output var  logic [4:0]                  output_rate_select,
    output var  logic [31:0]                 output_rate_mhz,
    output var  adc_regs_pkg::filter_mode_t  filter_mode,
    output var  logic                        conversion_restart
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] msg);
        logic [7:0] c;
        c = `CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ msg[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    function automatic logic [31:0] rate_decode(input logic [4:0] code);
        logic [31:0] r;
        r = 32'h0;
        unique case (code)
            5'h00: r = 32'd2500;
            5'h01: r = 32'd5000;
            5'h02: r = 32'd10000;
            5'h03: r = 32'd16600;
            5'h04: r = 32'd20000;
            5'h05: r = 32'd50000;
            5'h06: r = 32'd60000;
            5'h07: r = 32'd100000;
            5'h09: r = 32'd1200000;
            5'h0a: r = 32'd2400000;
            5'h0b: r = 32'd4800000;
            5'h0c: r = 32'd7200000;
            5'h0d: r = 32'd14400000;
            default: r = 32'h0;
        endcase
        return r;
    endfunction : rate_decode

    function automatic adc_regs_pkg::filter_mode_t filter_decode(input logic [7:0] cfg);
        adc_regs_pkg::filter_mode_t f;
        if (cfg[`RATE_MSB:`RATE_LSB] >= `RATE_SINC5_MIN) begin
            f = adc_regs_pkg::FILT_SINC5;
        end else begin
            unique case (cfg[`FILT_MSB:`FILT_LSB])
                3'h0:    f = adc_regs_pkg::FILT_SINC1;
                3'h2:    f = adc_regs_pkg::FILT_SINC3;
                3'h3:    f = adc_regs_pkg::FILT_SINC4;
                3'h4:    f = adc_regs_pkg::FILT_FIR;
                default: f = adc_regs_pkg::FILT_RESERVED;
            endcase
        end
        return f;
    endfunction : filter_decode

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three stages; a level is accepted only when stages two and three agree
    adc_regs_pkg::link_pins_t pins;
    adc_regs_pkg::link_pins_t s1_q, s2_q, s3_q;
    adc_regs_pkg::link_pins_t filt_q, filt_d, last_q;

    assign pins = '{sclk: sclk, cs_n: chip_select_converter_n, din: din};

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q   <= 3'b010;
            s2_q   <= 3'b010;
            s3_q   <= 3'b010;
            filt_q <= 3'b010;
            last_q <= 3'b010;
        end else begin
            s1_q   <= pins;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
            last_q <= filt_q;
        end
    end

    // ----------------------------------------
    // Frame engine and registers
    // ----------------------------------------
    adc_regs_pkg::phase_t       phase_q, phase_d;
    adc_regs_pkg::main_status_t status_now;
    adc_regs_pkg::filter_mode_t filter_d;
    logic [2:0]  bit_q, bit_d;
    logic [7:0]  shift_q, shift_d, cmd_q, cmd_d, data_q, data_d, tx_q, tx_d;
    logic [7:0]  config_q, config_d, byte_in;
    logic        crc_q, crc_d, rst_q, rst_d, new_q, new_d, ref_q, ref_d;
    logic        restart_d, crc_event, wr_status, wr_config, is_rd, is_wr;
    logic        cs_on, sclk_rise, sclk_fall;
    logic [31:0] rate_d;
    logic [4:0]  addr;

    assign cs_on     = ~filt_q.cs_n;
    assign sclk_rise = ~last_q.sclk & filt_q.sclk;
    assign sclk_fall = last_q.sclk & ~filt_q.sclk;
    assign byte_in   = {shift_q[6:0], filt_q.din};
    assign addr      = cmd_q[`CMD_ADDR_MSB:0];
    assign is_rd     = cmd_q[`CMD_OP_MSB:`CMD_OP_LSB] == 3'(`CMD_READ_BASE >> `CMD_OP_LSB);
    assign is_wr     = cmd_q[`CMD_OP_MSB:`CMD_OP_LSB] == 3'(`CMD_WRITE_BASE >> `CMD_OP_LSB);
    // Reserved bits forced low, summary and clock bits are live inputs
    assign status_now = '{rsvd7: 1'b0, checksum_fault_primary: crc_q, rsvd5: 1'b0,
                          secondary_error_summary: secondary_errors_logged,
                          reference_low_alarm: ref_q, new_result_flag: new_q,
                          clock_external: clock_external, reset_seen: rst_q};

    always_comb begin
        phase_d   = phase_q;
        bit_d     = bit_q;
        shift_d   = shift_q;
        cmd_d     = cmd_q;
        data_d    = data_q;
        tx_d      = tx_q;
        crc_event = 1'b0;
        wr_status = 1'b0;
        wr_config = 1'b0;
        if (!cs_on) begin
            phase_d = adc_regs_pkg::PH_CMD;
            bit_d   = 3'h0;
            tx_d    = `TX_IDLE_BYTE;
        end else if (sclk_rise && bit_q != 3'h0) begin
            tx_d = {tx_q[6:0], 1'b0};
        end else if (sclk_fall) begin
            shift_d = byte_in;
            bit_d   = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
                unique case (phase_q)
                    adc_regs_pkg::PH_CMD: begin
                        cmd_d   = byte_in;
                        tx_d    = byte_in;
                        phase_d = adc_regs_pkg::PH_DATA;
                    end
                    adc_regs_pkg::PH_DATA: begin
                        data_d  = byte_in;
                        tx_d    = byte_in;
                        phase_d = adc_regs_pkg::PH_CHECK;
                    end
                    adc_regs_pkg::PH_CHECK: begin
                        phase_d = adc_regs_pkg::PH_REPLY;
                        tx_d    = `TX_ZERO_BYTE;
                        // A bad checksum drops the command; only this select reaches here
                        if (byte_in != crc8({cmd_q, data_q})) begin
                            crc_event = 1'b1;
                        end else if (is_wr) begin
                            wr_status = addr == `ADDR_STATUS;
                            wr_config = addr == `ADDR_CONFIG;
                        end else if (is_rd) begin
                            unique case (addr)
                                `ADDR_IDENT:  tx_d = {PART_CODE, REV_CODE};
                                `ADDR_STATUS: tx_d = status_now;
                                `ADDR_CONFIG: tx_d = config_q;
                                default:      tx_d = `TX_ZERO_BYTE;
                            endcase
                        end
                    end
                    adc_regs_pkg::PH_REPLY: begin
                        phase_d = adc_regs_pkg::PH_DONE;
                        tx_d    = `TX_ZERO_BYTE;
                    end
                    adc_regs_pkg::PH_DONE: begin
                        tx_d = `TX_ZERO_BYTE;
                    end
                endcase
            end
        end
        // Set wins over a clear in the same cycle
        crc_d     = crc_event | (crc_q & ~(wr_status & ~data_q[`STAT_CRC_BIT]));
        rst_d     = rst_q & ~(wr_status & ~data_q[`STAT_RST_BIT]);
        new_d     = conversion_done | (new_q & ~data_read);
        ref_d     = conversion_start ? reference_below_limit : ref_q;
        config_d  = wr_config ? data_q : config_q;
        restart_d = wr_config;
        rate_d    = rate_decode(config_d[`RATE_MSB:`RATE_LSB]);
        filter_d  = filter_decode(config_d);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q            <= adc_regs_pkg::PH_CMD;
            bit_q              <= 3'h0;
            shift_q            <= 8'h00;
            cmd_q              <= 8'h00;
            data_q             <= 8'h00;
            tx_q               <= `TX_IDLE_BYTE;
            crc_q              <= 1'b0;
            rst_q              <= 1'b1;
            new_q              <= 1'b0;
            ref_q              <= 1'b0;
            config_q           <= `CONFIG_RESET;
            conversion_restart <= 1'b0;
            output_rate_mhz    <= 32'd20000;
            filter_mode        <= adc_regs_pkg::FILT_FIR;
            dout_oe_n          <= 1'b1;
        end else begin
            phase_q            <= phase_d;
            bit_q              <= bit_d;
            shift_q            <= shift_d;
            cmd_q              <= cmd_d;
            data_q             <= data_d;
            tx_q               <= tx_d;
            crc_q              <= crc_d;
            rst_q              <= rst_d;
            new_q              <= new_d;
            ref_q              <= ref_d;
            config_q           <= config_d;
            conversion_restart <= restart_d;
            output_rate_mhz    <= rate_d;
            filter_mode        <= filter_d;
            dout_oe_n          <= ~cs_on;
        end
    end

    assign dout               = tx_q[7];
    assign output_rate_select = config_q[`RATE_MSB:`RATE_LSB];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_good_check;
        sclk_fall && cs_on && bit_q == 3'h7 && phase_q == adc_regs_pkg::PH_CHECK
            && byte_in == crc8({cmd_q, data_q});
    endsequence

    property p_id_read;
        s_good_check and (is_rd && addr == `ADDR_IDENT) |=> tx_q == {PART_CODE, REV_CODE};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification read wrong");

    property p_crc_set;
        crc_event |=> crc_q [*2];
    endproperty
    a_crc_set: assert property (p_crc_set) else $error("checksum fault not held");

    property p_crc_cause;
        $rose(crc_q) |-> $past(cs_on) && $past(phase_q) == adc_regs_pkg::PH_CHECK;
    endproperty
    a_crc_cause: assert property (p_crc_cause) else $error("checksum fault without frame");

    // Checked on the byte actually shifted out, not on the live status vector
    property p_summary;
        s_good_check and (is_rd && addr == `ADDR_STATUS)
            |=> !tx_q[7] && !tx_q[5] && tx_q[4] == $past(secondary_errors_logged);
    endproperty
    a_summary: assert property (p_summary) else $error("summary or reserved bit wrong");

    property p_ref_hold;
        !conversion_start |=> $stable(ref_q);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("alarm moved between conversions");

    property p_new_set;
        conversion_done |=> new_q;
    endproperty
    a_new_set: assert property (p_new_set) else $error("new result flag lost");

    property p_clock_bit;
        s_good_check and (is_rd && addr == `ADDR_STATUS) |=> tx_q[1] == $past(clock_external);
    endproperty
    a_clock_bit: assert property (p_clock_bit) else $error("clock source bit wrong");

    property p_rst_hold;
        rst_q && !wr_status |=> rst_q;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset flag dropped");

    property p_rate_default;
        config_q[`RATE_MSB:`RATE_LSB] == 5'h04 |=> output_rate_mhz == 32'd20000 || $changed(config_q);
    endproperty
    a_rate_default: assert property (p_rate_default) else $error("20 SPS decode wrong");

    property p_rate_fast;
        config_q[`RATE_MSB:`RATE_LSB] == 5'h0d ##1 $stable(config_q) |-> output_rate_mhz == 32'd14400000;
    endproperty
    a_rate_fast: assert property (p_rate_fast) else $error("14.4 kSPS decode wrong");

    property p_fir;
        config_q == `CONFIG_RESET ##1 $stable(config_q) |-> filter_mode == adc_regs_pkg::FILT_FIR;
    endproperty
    a_fir: assert property (p_fir) else $error("FIR decode wrong");

    property p_sinc5;
        config_q[`RATE_MSB:`RATE_LSB] >= `RATE_SINC5_MIN ##1 $stable(config_q)
            |-> filter_mode == adc_regs_pkg::FILT_SINC5;
    endproperty
    a_sinc5: assert property (p_sinc5) else $error("sinc5 not forced");

    property p_restart;
        s_good_check and (is_wr && addr == `ADDR_CONFIG) |=> conversion_restart && config_q == data_q;
    endproperty
    a_restart: assert property (p_restart) else $error("config write did not restart");

endmodule : adc_regs

`default_nettype wire

// ===== verification/host_link_model.sv
// Host controller model issuing register commands over the serial link
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
    input  wire logic clk,
    input  wire logic dout,
    input  wire logic dout_oe_n,
    output var  logic sclk,
    output var  logic chip_select_converter_n,
    output var  logic din
);

    // ------------------------------------
    // Idle link
    // ------------------------------------
    initial begin
        sclk = 1'b0;
        chip_select_converter_n = 1'b1;
        din = 1'b0;
    end

    // ------------------------------------
    // Frame checksum and transfer
    // ------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8

    task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data,
                          input logic bad, output logic [31:0] rx, output logic ok);
        logic [7:0]  cmd;
        logic [31:0] tx;
        cmd = wr ? 8'h40 + 8'(addr) : 8'h20 + 8'(addr);
        tx = {cmd, data, crc8({cmd, data}) ^ {7'h0, bad}, 8'h00};
        ok = 1'b0;
        rx = 32'h0;
        @(posedge clk);
        #5 chip_select_converter_n = 1'b0;
        // Enable is launched on the edge; look once it has settled
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk);
            #5 ok = (dout_oe_n === 1'b0);
        end
        // Link edges kept off the system clock phase
        #32;
        for (int i = 31; i >= 0; i--) begin
            din = tx[i];
            sclk = 1'b1;
            #400 sclk = 1'b0;
            #400 rx[i] = dout;
        end
        #400 chip_select_converter_n = 1'b1;
        // Released line must not keep its last bit
        din = ~din;
        repeat (10) @(posedge clk);
    endtask : access

endmodule : host_link_model

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_cfg.svh"

module tb_top;
    localparam logic [3:0] PART = 4'h6; // Arbitrary value
    localparam logic [3:0] REV  = 4'h3; // Arbitrary value
    localparam logic [4:0] CODES [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
                                         5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
    localparam int         MHZ [13] = '{2500, 5000, 10000, 16600, 20000, 50000, 60000,
                                        100000, 1200000, 2400000, 4800000, 7200000, 14400000};
    // FIR only beside the three slowest rates and the 20 SPS rate (code 04)
    localparam logic [2:0] FSEL [13] = '{3'h4, 3'h4, 3'h4, 3'h0, 3'h4, 3'h2, 3'h3,
                                        3'h0, 3'h2, 3'h3, 3'h0, 3'h2, 3'h3};

    logic clk, reset_n, sclk, cs_n, din, dout, dout_oe_n, restart, link_ok;
    logic conv_start, conv_done, data_read, ref_low, clk_ext, sec_err;
    logic [4:0]  rate_sel;
    logic [31:0] rate_mhz, rx;
    adc_regs_pkg::filter_mode_t filt;
    int n_fail, n_checks;
    int n_restart = 0;

    adc_regs #(.PART_CODE(PART), .REV_CODE(REV)) dut_u (
        .clk(clk), .reset_n(reset_n), .sclk(sclk), .chip_select_converter_n(cs_n), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n), .conversion_start(conv_start),
        .conversion_done(conv_done), .data_read(data_read), .reference_below_limit(ref_low),
        .clock_external(clk_ext), .secondary_errors_logged(sec_err),
        .output_rate_select(rate_sel), .output_rate_mhz(rate_mhz), .filter_mode(filt),
        .conversion_restart(restart));

    host_link_model host_u (.clk(clk), .dout(dout), .dout_oe_n(dout_oe_n), .sclk(sclk),
        .chip_select_converter_n(cs_n), .din(din));

    always #50 clk = ~clk;
    always @(posedge clk) if (restart === 1'b1) n_restart <= n_restart + 1;

    // ------------------------------------
    // Shared tasks
    // ------------------------------------
    task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task stop_test;
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    task xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic bad);
        host_u.access(wr, a, d, bad, rx, link_ok);
        check("select answer", 32'h1, 32'(link_ok));
        check("echo bytes", {8'h0, 8'hff, (wr ? 8'h40 : 8'h20) + 8'(a), d}, {8'h0, rx[31:8]});
        if (wr) check("write reply", 32'h0, 32'(rx[7:0]));
        check("output released", 32'h1, 32'(dout_oe_n));
    endtask : xfer

    task rd(input logic [4:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00, 1'b0);
        check("register byte", 32'(exp), 32'(rx[7:0]));
    endtask : rd

    task pulse(input int which);
        @(posedge clk);
        #5;
        if (which == 0) conv_start = 1'b1;
        else if (which == 1) conv_done = 1'b1;
        else data_read = 1'b1;
        @(posedge clk);
        #5;
        conv_start = 1'b0;
        conv_done = 1'b0;
        data_read = 1'b0;
    endtask : pulse

    task levels(input logic ext, input logic sec, input logic rl);
        @(posedge clk);
        #5;
        clk_ext = ext;
        sec_err = sec;
        ref_low = rl;
    endtask : levels

    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task sc_reset_values;
        rd(`ADDR_IDENT, {PART, REV});
        rd(`ADDR_STATUS, `STATUS_RESET);
        rd(`ADDR_CONFIG, `CONFIG_RESET);
        check("rate", 32'd20000, rate_mhz);
        check("filter", 32'h4, 32'(filt));
        rd(5'h03, 8'h00);
    endtask : sc_reset_values

    task sc_ident_locked;
        int r0;
        r0 = n_restart;
        xfer(1'b1, `ADDR_IDENT, 8'h5a, 1'b0);
        rd(`ADDR_IDENT, {PART, REV});
        check("restart count", 32'(r0), 32'(n_restart));
    endtask : sc_ident_locked

    task sc_checksum_fault;
        int r0;
        r0 = n_restart;
        xfer(1'b1, `ADDR_CONFIG, 8'h6b, 1'b1);
        check("restart count", 32'(r0), 32'(n_restart));
        rd(`ADDR_CONFIG, `CONFIG_RESET);
        rd(`ADDR_STATUS, 8'h41);
        xfer(1'b1, `ADDR_STATUS, 8'h00, 1'b0);
        rd(`ADDR_STATUS, 8'h00);
    endtask : sc_checksum_fault

    task sc_status_flags;
        levels(1'b1, 1'b1, 1'b0);
        rd(`ADDR_STATUS, 8'h12);
        levels(1'b0, 1'b0, 1'b1);
        rd(`ADDR_STATUS, 8'h00);
        pulse(0);
        rd(`ADDR_STATUS, 8'h08);
        levels(1'b0, 1'b0, 1'b0);
        rd(`ADDR_STATUS, 8'h08);
        pulse(0);
        rd(`ADDR_STATUS, 8'h00);
        pulse(1);
        rd(`ADDR_STATUS, 8'h04);
        xfer(1'b1, `ADDR_STATUS, 8'h00, 1'b0);
        rd(`ADDR_STATUS, 8'h04);
        pulse(2);
        rd(`ADDR_STATUS, 8'h00);
    endtask : sc_status_flags

    task sc_rate_filter;
        int r0;
        for (int i = 0; i < 13; i++) begin
            r0 = n_restart;
            xfer(1'b1, `ADDR_CONFIG, {CODES[i], FSEL[i]}, 1'b0);
            check("restart count", 32'(r0 + 1), 32'(n_restart));
            check("rate code", 32'(CODES[i]), 32'(rate_sel));
            check("rate", 32'(MHZ[i]), rate_mhz);
            check("filter", (i == 12) ? 32'h5 : 32'(FSEL[i]), 32'(filt));
            rd(`ADDR_CONFIG, {CODES[i], FSEL[i]});
        end
    endtask : sc_rate_filter

    task sc_second_reset;
        @(posedge clk);
        #5 reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #5 reset_n = 1'b1;
        rd(`ADDR_STATUS, `STATUS_RESET);
        check("rate", 32'd20000, rate_mhz);
    endtask : sc_second_reset

    // ------------------------------------
    // Main sequence
    // ------------------------------------
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {conv_start, conv_done, data_read, ref_low, clk_ext, sec_err} = 6'h00;
        n_fail = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        #5 reset_n = 1'b1;
        sc_reset_values;
        sc_ident_locked;
        sc_checksum_fault;
        sc_status_flags;
        sc_rate_filter;
        sc_second_reset;
        stop_test;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        $display("unexpected run length: expected end seen timeout");
        stop_test;
    end

endmodule : tb_top

`default_nettype wire
